/* src/flash_erase_pkg.sv */
package flash_erase_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  // ==========================================================
  localparam logic [11:0] READY_OFS         = 12'h400;
  localparam logic [11:0] CONFIG_OFS        = 12'h504;
  localparam logic [11:0] PAGE_ERASE_OFS    = 12'h508;
  localparam logic [11:0] CHIP_ERASE_OFS    = 12'h50c;
  localparam logic [11:0] LEGACY_PAGE_OFS   = 12'h510;
  localparam logic [11:0] UCFG_ERASE_OFS    = 12'h514;
  localparam logic [11:0] PART_ADDR_OFS     = 12'h518;
  localparam logic [11:0] PART_LEN_OFS      = 12'h51c;

  // ==========================================================
  // fields and reset values
  // ==========================================================
  localparam int          MODE_W            = 2;
  localparam int          LEN_W             = 7;
  localparam int          TRIG_BIT          = 0;
  localparam int          READY_BIT         = 0;
  localparam logic [1:0]  MODE_RESET        = 2'h0;
  localparam logic [6:0]  LEN_RESET         = 7'h0a;
  localparam logic [31:0] ADDR_RESET        = 32'h0000_0000;

  // access mode codes
  localparam logic [1:0]  MODE_READ_ONLY    = 2'h0;
  localparam logic [1:0]  MODE_WRITE_EN     = 2'h1;
  localparam logic [1:0]  MODE_ERASE_EN     = 2'h2;

  // operation codes driven to the array
  localparam logic [2:0]  OP_NONE           = 3'h0;
  localparam logic [2:0]  OP_PROGRAM        = 3'h1;
  localparam logic [2:0]  OP_PAGE_WIPE      = 3'h2;
  localparam logic [2:0]  OP_UCFG_WIPE      = 3'h3;
  localparam logic [2:0]  OP_CHIP_WIPE      = 3'h4;
  localparam logic [2:0]  OP_PART_WIPE      = 3'h5;

  // axi responses
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int          CLK_MHZ           = 250;
  localparam int          WORD_WRITE_US     = 41;
  localparam int          PAGE_WIPE_MS      = 85;
  localparam int          CHIP_WIPE_MS      = 169;
  localparam int          ACC_PERMILLE      = 1050;
  localparam int          MS_CYC            = CLK_MHZ * 1000;
  localparam int          WORD_WRITE_CYC    = WORD_WRITE_US * CLK_MHZ;
  localparam int          PAGE_WIPE_CYC     = PAGE_WIPE_MS * MS_CYC;
  localparam int          CHIP_WIPE_CYC     = CHIP_WIPE_MS * MS_CYC;

endpackage

/* src/op_timer.sv */
`timescale 1ns/100ps
module op_timer
(
  input  wire logic        clk_sys,  // system clock
  input  wire logic        sys_rst,  // async reset
  input  wire logic        start,    // load and run
  input  wire logic [31:0] load,     // cycles to run
  output logic             busy,     // counting
  output logic             done      // last cycle pulse
);

  logic [31:0] count_ff;
  logic        busy_ff;
  logic        done_ff;

  // ==========================================================
  // down counter, done marks the last of load cycles
  // zero load runs one cycle
  // ==========================================================
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count_ff <= 32'h0;
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end
    else if (start)
    begin
      count_ff <= (load == 32'h0) ? 32'h1 : load;
      busy_ff  <= (load > 32'h1);
      done_ff  <= (load <= 32'h1);
    end
    else if (busy_ff)
    begin
      count_ff <= count_ff - 32'h1;
      busy_ff  <= (count_ff > 32'h2);
      done_ff  <= (count_ff == 32'h2);
    end
    else
    begin
      done_ff <= 1'b0;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;

endmodule // op_timer

/* src/flash_erase_command_control.sv */
// What this block does
// - chip trigger 1 wipes everything, 0 nothing
// - erases only start in erase-enabled mode
// - mode 0 read, 1 write, 2 erase
// - legacy register acts as page erase
// - config-area trigger 1 wipes it, 0 nothing
// - partial address write starts partial wipe
// - partial length 7-bit ms, reset ten
// - accumulated partials reaching full time count once
// - word program ends within 41 us, cpu held
// - page wipe ends within 85 ms
// - chip wipe ends within 169 ms
// - partial lasts length ms times up to 1.05
// - ready reads 0 busy, 1 idle
`timescale 1ns/100ps
module flash_erase_command_control
#(
  parameter int WRITE_CYC = flash_erase_pkg::WORD_WRITE_CYC,
  parameter int PAGE_CYC  = flash_erase_pkg::PAGE_WIPE_CYC,
  parameter int CHIP_CYC  = flash_erase_pkg::CHIP_WIPE_CYC,
  parameter int MS_CYCLES = flash_erase_pkg::MS_CYC
)
(
  input  wire logic        clk_sys,        // 250 MHz clock
  input  wire logic        sys_rst,        // async reset, high
  input  wire logic [11:0] awaddr,         // write address
  input  wire logic [2:0]  awprot,         // unused protection
  input  wire logic        awvalid,        // write address valid
  output logic             awready,        // write address ready
  input  wire logic [31:0] wdata,          // write data
  input  wire logic [3:0]  wstrb,          // byte strobes
  input  wire logic        wvalid,         // write data valid
  output logic             wready,         // write data ready
  output logic [1:0]       bresp,          // write response
  output logic             bvalid,         // write response valid
  input  wire logic        bready,         // write response ready
  input  wire logic [11:0] araddr,         // read address
  input  wire logic [2:0]  arprot,         // unused protection
  input  wire logic        arvalid,        // read address valid
  output logic             arready,        // read address ready
  output logic [31:0]      rdata,          // read data
  output logic [1:0]       rresp,          // read response
  output logic             rvalid,         // read data valid
  input  wire logic        rready,         // read data ready
  input  wire logic        prog_req,       // word program request
  input  wire logic [31:0] prog_addr,      // word address
  input  wire logic [31:0] prog_data,      // word value
  output logic             prog_done,      // program finished
  output logic             prog_refused,   // program not allowed
  output logic             cpu_hold,       // processor held off
  output logic [2:0]       array_op,       // running operation
  output logic [31:0]      array_addr,     // target address
  output logic [31:0]      array_wdata,    // word to program
  output logic             page_erased     // partials made a wipe
);
  import flash_erase_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_PROG = 6'b000010,
    ST_PAGE = 6'b000100,
    ST_UCFG = 6'b001000,
    ST_CHIP = 6'b010000,
    ST_PART = 6'b100000
  } op_state_e;

  op_state_e   state_ff;
  op_state_e   nxt_state;
  logic        aw_held_ff;
  logic        w_held_ff;
  logic [11:0] wr_addr_ff;
  logic [31:0] wr_data_ff;
  logic [3:0]  wr_strb_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [1:0]  mode_ff;
  logic [6:0]  part_len_ff;
  logic        ready_ff;
  logic [7:0]  part_acc_ff;
  logic [31:0] part_page_ff;
  logic        part_seen_ff;
  logic        prog_done_ff;
  logic        prog_refused_ff;
  logic        cpu_hold_ff;
  logic [2:0]  array_op_ff;
  logic [31:0] array_addr_ff;
  logic [31:0] array_wdata_ff;
  logic        page_erased_ff;
  logic [31:0] wr_masked;
  logic        wr_fire;
  logic        wr_mapped;
  logic        rd_mapped;
  logic        idle;
  logic        erase_ok;
  logic        go_page;
  logic        go_ucfg;
  logic        go_chip;
  logic        go_part;
  logic        go_prog;
  logic        tmr_start;
  logic [31:0] tmr_load;
  logic        tmr_busy;
  logic        tmr_done;
  logic [31:0] part_cyc;
  logic [7:0]  acc_sum;

  // ==========================================================
  // write channel capture, either order
  // ==========================================================
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

  generate
    for (genvar lane = 0; lane < 4; lane++)
    begin : g_lane
      assign wr_masked[lane*8 +: 8] =
        wr_strb_ff[lane] ? wr_data_ff[lane*8 +: 8] : 8'h00;
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      wr_addr_ff <= 12'h0;
    end
    else if (awvalid && awready_ff)
    begin
      aw_held_ff <= 1'b1;
      awready_ff <= 1'b0;
      wr_addr_ff <= awaddr;
    end
    else if (bvalid_ff && bready)
    begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b1;
    end
    else
    begin
      awready_ff <= !aw_held_ff && !bvalid_ff;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      w_held_ff  <= 1'b0;
      wready_ff  <= 1'b0;
      wr_data_ff <= 32'h0;
      wr_strb_ff <= 4'h0;
    end
    else if (wvalid && wready_ff)
    begin
      w_held_ff  <= 1'b1;
      wready_ff  <= 1'b0;
      wr_data_ff <= wdata;
      wr_strb_ff <= wstrb;
    end
    else if (bvalid_ff && bready)
    begin
      w_held_ff <= 1'b0;
      wready_ff <= 1'b1;
    end
    else
    begin
      wready_ff <= !w_held_ff && !bvalid_ff;
    end
  end

  always_comb
  begin
    unique case (wr_addr_ff)
      CONFIG_OFS, PAGE_ERASE_OFS, CHIP_ERASE_OFS, LEGACY_PAGE_OFS,
      UCFG_ERASE_OFS, PART_ADDR_OFS, PART_LEN_OFS: wr_mapped = 1'b1;
      default:                                     wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // configuration registers
  // ==========================================================
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      mode_ff <= MODE_RESET;
    else if (wr_fire && wr_addr_ff == CONFIG_OFS)
      mode_ff <= wr_masked[MODE_W-1:0];
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      part_len_ff <= LEN_RESET;
    else if (wr_fire && wr_addr_ff == PART_LEN_OFS && wr_strb_ff[0])
      part_len_ff <= wr_masked[LEN_W-1:0];
  end

  // ==========================================================
  // command decode, ignored while busy
  // ==========================================================
  assign idle     = (state_ff == ST_IDLE);
  assign erase_ok = idle && (mode_ff == MODE_ERASE_EN);
  assign go_page  = erase_ok && wr_fire &&
                    (wr_addr_ff == PAGE_ERASE_OFS ||
                     wr_addr_ff == LEGACY_PAGE_OFS);
  assign go_chip  = erase_ok && wr_fire &&
                    wr_addr_ff == CHIP_ERASE_OFS &&
                    wr_masked[TRIG_BIT];
  assign go_ucfg  = erase_ok && wr_fire &&
                    wr_addr_ff == UCFG_ERASE_OFS &&
                    wr_masked[TRIG_BIT];
  assign go_part  = erase_ok && wr_fire &&
                    wr_addr_ff == PART_ADDR_OFS;
  assign go_prog  = idle && prog_req && !prog_done_ff &&
                    (mode_ff == MODE_WRITE_EN) && !wr_fire;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (go_chip)
          nxt_state = ST_CHIP;
        else if (go_ucfg)
          nxt_state = ST_UCFG;
        else if (go_page)
          nxt_state = ST_PAGE;
        else if (go_part)
          nxt_state = ST_PART;
        else if (go_prog)
          nxt_state = ST_PROG;
      end
      ST_PROG, ST_PAGE, ST_UCFG, ST_CHIP, ST_PART:
      begin
        if (tmr_done)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // ==========================================================
  // operation timing
  // ==========================================================
  assign part_cyc  = 32'(part_len_ff) * 32'(MS_CYCLES);
  assign tmr_start = idle && (nxt_state != ST_IDLE);

  always_comb
  begin
    unique case (nxt_state)
      ST_PROG: tmr_load = 32'(WRITE_CYC);
      ST_CHIP: tmr_load = 32'(CHIP_CYC);
      ST_PART: tmr_load = part_cyc;
      default: tmr_load = 32'(PAGE_CYC);
    endcase
  end

  op_timer u_timer
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (tmr_start),
    .load    (tmr_load),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // ==========================================================
  // array side and status
  // ==========================================================
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      array_op_ff    <= OP_NONE;
      array_addr_ff  <= ADDR_RESET;
      array_wdata_ff <= 32'h0;
      ready_ff       <= 1'b1;
      cpu_hold_ff    <= 1'b0;
    end
    else if (tmr_start)
    begin
      ready_ff    <= 1'b0;
      cpu_hold_ff <= (nxt_state == ST_PROG);
      unique case (nxt_state)
        ST_PROG:
        begin
          array_op_ff    <= OP_PROGRAM;
          array_addr_ff  <= prog_addr;
          array_wdata_ff <= prog_data;
        end
        ST_CHIP: array_op_ff <= OP_CHIP_WIPE;
        ST_UCFG: array_op_ff <= OP_UCFG_WIPE;
        ST_PART:
        begin
          array_op_ff   <= OP_PART_WIPE;
          array_addr_ff <= wr_data_ff;
        end
        default:
        begin
          array_op_ff   <= OP_PAGE_WIPE;
          array_addr_ff <= wr_data_ff;
        end
      endcase
    end
    else if (tmr_done)
    begin
      array_op_ff <= OP_NONE;
      ready_ff    <= 1'b1;
      cpu_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prog_done_ff    <= 1'b0;
      prog_refused_ff <= 1'b0;
    end
    else
    begin
      prog_done_ff    <= tmr_done && (state_ff == ST_PROG);
      prog_refused_ff <= idle && prog_req && !prog_done_ff &&
                         !prog_refused_ff &&
                         (mode_ff != MODE_WRITE_EN);
    end
  end

  // ==========================================================
  // partial wipe accumulation per page
  // ==========================================================
  assign acc_sum = part_acc_ff + 8'(part_len_ff);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      part_acc_ff    <= 8'h0;
      part_page_ff   <= ADDR_RESET;
      part_seen_ff   <= 1'b0;
      page_erased_ff <= 1'b0;
    end
    else
    begin
      page_erased_ff <= 1'b0;
      if (tmr_done && state_ff == ST_PART)
      begin
        if (acc_sum >= 8'(PAGE_WIPE_MS))
        begin
          part_acc_ff    <= 8'h0;
          page_erased_ff <= 1'b1;
        end
        else
          part_acc_ff <= acc_sum;
      end
      else if (tmr_start && nxt_state == ST_PART &&
               (!part_seen_ff || wr_data_ff != part_page_ff))
      begin
        part_acc_ff  <= 8'h0;
        part_page_ff <= wr_data_ff;
        part_seen_ff <= 1'b1;
      end
      else if (tmr_start && !(nxt_state inside {ST_PROG, ST_PART}))
        part_seen_ff <= 1'b0;
    end
  end

  // ==========================================================
  // read channel
  // ==========================================================
  always_comb
  begin
    unique case (araddr)
      READY_OFS, CONFIG_OFS, PAGE_ERASE_OFS, CHIP_ERASE_OFS,
      LEGACY_PAGE_OFS, UCFG_ERASE_OFS, PART_ADDR_OFS,
      PART_LEN_OFS: rd_mapped = 1'b1;
      default:      rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= RESP_OKAY;
    end
    else if (arvalid && arready_ff)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr)
        READY_OFS:    rdata_ff <= {31'h0, ready_ff};
        CONFIG_OFS:   rdata_ff <= {30'h0, mode_ff};
        PART_LEN_OFS: rdata_ff <= {25'h0, part_len_ff};
        default:      rdata_ff <= 32'h0;
      endcase
    end
    else if (rvalid_ff && rready)
    begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
    else
    begin
      arready_ff <= !rvalid_ff;
    end
  end

  assign awready      = awready_ff;
  assign wready       = wready_ff;
  assign bvalid       = bvalid_ff;
  assign bresp        = bresp_ff;
  assign arready      = arready_ff;
  assign rvalid       = rvalid_ff;
  assign rdata        = rdata_ff;
  assign rresp        = rresp_ff;
  assign prog_done    = prog_done_ff;
  assign prog_refused = prog_refused_ff;
  assign cpu_hold     = cpu_hold_ff;
  assign array_op     = array_op_ff;
  assign array_addr   = array_addr_ff;
  assign array_wdata  = array_wdata_ff;
  assign page_erased  = page_erased_ff;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic [31:0] op_age_ff;
  logic [31:0] part_lim;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      op_age_ff <= 32'h0;
    else if (tmr_start)
      op_age_ff <= 32'h1;
    else if (!idle)
      op_age_ff <= op_age_ff + 32'h1;
  end

  assign part_lim = 32'((64'(part_cyc) * 64'(ACC_PERMILLE)) / 64'd1000);

  sequence s_erase_cmd;
    wr_fire && erase_ok && (wr_addr_ff == LEGACY_PAGE_OFS);
  endsequence

  sequence s_page_running;
    (state_ff == ST_PAGE) && (array_op_ff == OP_PAGE_WIPE);
  endsequence

  legacy_page_a: assert property (s_erase_cmd |=> s_page_running
    and (array_addr_ff == $past(wr_data_ff)))
    else $error("legacy page write did not start page wipe");

  erase_gate_a: assert property (idle && nxt_state inside
    {ST_PAGE, ST_UCFG, ST_CHIP, ST_PART} |-> mode_ff == MODE_ERASE_EN)
    else $error("erase started outside erase mode");

  chip_trigger_a: assert property ($rose(state_ff == ST_CHIP)
    |-> $past(wr_masked[TRIG_BIT]) && $past(wr_addr_ff) == CHIP_ERASE_OFS)
    else $error("chip wipe without a one written");

  ucfg_trigger_a: assert property (wr_fire && erase_ok
    && wr_addr_ff == UCFG_ERASE_OFS |=> (state_ff == ST_UCFG)
    == $past(wr_masked[TRIG_BIT]))
    else $error("config area wipe trigger mismatch");

  partial_start_a: assert property (wr_fire && erase_ok
    && wr_addr_ff == PART_ADDR_OFS |=> state_ff == ST_PART
    && array_addr_ff == $past(wr_data_ff))
    else $error("partial wipe not started at written page");

  prog_mode_a: assert property ($rose(state_ff == ST_PROG)
    |-> $past(mode_ff) == MODE_WRITE_EN && cpu_hold_ff)
    else $error("program outside write mode");

  prog_time_a: assert property (state_ff == ST_PROG
    |-> op_age_ff <= 32'(WRITE_CYC))
    else $error("word program too long");

  page_time_a: assert property (state_ff inside {ST_PAGE, ST_UCFG}
    |-> op_age_ff <= 32'(PAGE_CYC))
    else $error("page wipe too long");

  chip_time_a: assert property (state_ff == ST_CHIP
    |-> op_age_ff <= 32'(CHIP_CYC))
    else $error("chip wipe too long");

  partial_time_a: assert property (state_ff == ST_PART
    |-> op_age_ff <= part_lim)
    else $error("partial wipe too long");

  ready_flag_a: assert property (ready_ff
    == idle)
    else $error("ready flag wrong around an operation");

  len_reset_a: assert property ($fell(sys_rst) |-> part_len_ff
    == LEN_RESET)
    else $error("partial length not ten after reset");

  acc_count_a: assert property (page_erased_ff
    |-> $past(acc_sum) >= 8'(PAGE_WIPE_MS) && part_acc_ff == 8'h0)
    else $error("page counted erased too early");

endmodule // flash_erase_command_control

/* verification/flash_array_model.sv */
`timescale 1ns/100ps
module flash_array_model
(
  input  wire logic        clk_sys,     // clock
  input  wire logic        sys_rst,     // reset
  input  wire logic [2:0]  array_op,    // running op
  input  wire logic [31:0] array_addr,  // target word
  input  wire logic        page_erased, // partial sum done
  output int               wipes,       // pages wiped by partial sums
  output int               overwrites   // words written too often
);
  import flash_erase_pkg::*;
  logic [2:0] op_ff;
  int         wr_cnt[logic [31:0]];
  // =====================================================
  // array bookkeeping
  // =====================================================
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      op_ff <= OP_NONE;
      wipes <= 0;
      overwrites <= 0;
    end
    else
    begin
      op_ff <= array_op;
      if (page_erased)
        wipes <= wipes + 1;
      if (array_op == OP_PROGRAM && op_ff != OP_PROGRAM)
      begin
        if (!wr_cnt.exists(array_addr))
          wr_cnt[array_addr] = 0;
        wr_cnt[array_addr] = wr_cnt[array_addr] + 1;
        if (wr_cnt[array_addr] > 2)
          overwrites <= overwrites + 1;
      end
      if (array_op inside {OP_PAGE_WIPE, OP_CHIP_WIPE} || page_erased)
        wr_cnt.delete();
    end
  end
endmodule // flash_array_model

/* verification/flash_erase_command_control_tb_top.sv */
`timescale 1ns/100ps
module flash_erase_command_control_tb_top;
  import flash_erase_pkg::*;
  logic clk_sys = 0, sys_rst = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, prog_addr = 0, prog_data = 0, array_addr;
  logic [31:0] array_wdata, d, a0;
  logic [1:0] bresp, rresp, r;
  logic [2:0] array_op, prot = 3'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, prog_req = 0, prog_done;
  logic prog_refused, cpu_hold, page_erased, hold_seen;
  int n_errors = 0, n_tests = 0, wipes, overwrites, n;
  always #2 clk_sys = ~clk_sys;
  flash_erase_command_control #(.WRITE_CYC(20), .PAGE_CYC(85),
    .CHIP_CYC(169), .MS_CYCLES(4)) uut (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .awaddr(awaddr), .awprot(prot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(prot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data),
    .prog_done(prog_done), .prog_refused(prog_refused),
    .cpu_hold(cpu_hold), .array_op(array_op), .array_addr(array_addr),
    .array_wdata(array_wdata), .page_erased(page_erased));
  flash_array_model far (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .array_op(array_op), .array_addr(array_addr),
    .page_erased(page_erased), .wipes(wipes), .overwrites(overwrites));
  // =====================================================
  // bus and check tasks
  // =====================================================
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk_sys);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do
    begin
      @(posedge clk_sys);
      if (!ad && awready) begin ad = 1; awvalid <= 0; end
      if (!wd && wready) begin wd = 1; wvalid <= 0; end
    end while (!(ad && wd));
    do @(posedge clk_sys); while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 0;
    do @(posedge clk_sys); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  // checks the op that the last write launched, then waits it out
  task automatic run(input string nm, input logic [2:0] op);
    chk(nm, op, array_op);
    a0 = array_addr;
    n = 0;
    while (array_op != OP_NONE && n < 1000)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  // one ms is four cycles here, accuracy factor up to 1.05
  task automatic partial(input int ms);
    wr(CONFIG_OFS, 32'h2);
    wr(PART_ADDR_OFS, 32'h0000_2000);
    run("partial op", OP_PART_WIPE);
    chk("partial time", 1, n >= ms * 4 && n * 100 <= ms * 420);
    chk("partial addr", 32'h0000_2000, a0);
    wr(CONFIG_OFS, 32'h0);
  endtask
  task automatic prog(input logic [31:0] v);
    hold_seen = 0;
    @(posedge clk_sys);
    prog_addr <= 32'h0000_3000; prog_data <= v; prog_req <= 1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (cpu_hold) begin hold_seen = 1; d = array_wdata; end
    end while (!prog_done && !prog_refused && n < 100);
    prog_req <= 0;
  endtask
  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // =====================================================
  // scenarios
  // =====================================================
  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 0;
    prot <= 3'h7;
    rd(READY_OFS); chk("ready rst", 32'h1, d);
    rd(PART_LEN_OFS); chk("len rst", 32'ha, d);
    rd(CONFIG_OFS); chk("mode rst", 32'h0, d);
    rd(12'h600); chk("unmapped", RESP_SLVERR, r);
    wr(CHIP_ERASE_OFS, 32'h1); run("erase ro", OP_NONE);
    wr(CONFIG_OFS, 32'h1); wr(CHIP_ERASE_OFS, 32'h1);
    run("erase wen", OP_NONE);
    wr(CONFIG_OFS, 32'h2); rd(CONFIG_OFS); chk("mode", 32'h2, d);
    wr(CHIP_ERASE_OFS, 32'h0); run("chip 0", OP_NONE);
    wr(CHIP_ERASE_OFS, 32'h1); run("chip", OP_CHIP_WIPE);
    chk("chip time", 1, n <= 169);
    wr(UCFG_ERASE_OFS, 32'h0); run("ucfg 0", OP_NONE);
    wr(UCFG_ERASE_OFS, 32'h1); run("ucfg", OP_UCFG_WIPE);
    wr(LEGACY_PAGE_OFS, 32'h0000_1000);
    rd(READY_OFS); chk("ready busy", 32'h0, d);
    run("legacy", OP_PAGE_WIPE);
    chk("legacy addr", 32'h0000_1000, a0);
    chk("page time", 1, n <= 85);
    wr(PART_LEN_OFS, 32'hff); rd(PART_LEN_OFS); chk("len w", 32'h7f, d);
    wstrb <= 4'h0;
    wr(PART_LEN_OFS, 32'h05);
    wstrb <= 4'hf;
    rd(PART_LEN_OFS); chk("len strb", 32'h7f, d);
    wr(PART_LEN_OFS, 32'h1d);
    partial(29);
    chk("no wipe 1", 0, wipes);
    partial(29);
    chk("no wipe 2", 0, wipes);
    partial(29);
    @(posedge clk_sys);
    chk("one wipe", 1, wipes);
    prog(32'hffff_00ff); chk("refused", 1, prog_refused);
    wr(CONFIG_OFS, 32'h1);
    prog(32'hffff_00ff); chk("prog", 1, prog_done);
    // n also counts the request edge and one edge of sampling lag
    chk("prog time", 1, n <= 22);
    chk("hold", 1, hold_seen);
    chk("prog data", 32'hffff_00ff, d);
    prog(32'hffff_000f); chk("prog 2", 1, prog_done);
    chk("overwrites", 0, overwrites);
    stop_test();
  end
  initial
  begin
    #20000;
    n_errors++;
    stop_test();
  end
endmodule // flash_erase_command_control_tb_top
